// *** logic/ppwm_top.sv ***
// Pulse period and pulse width measurement channel with AXI4-Lite registers
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ppwm_cfg.svh"

module ppwm_top
#(
  parameter int CNT_W = 16
)
(
  input  wire logic                REF_CLK,
  input  wire logic                RSTN,
  input  wire logic                SUBCLK_TICK,
  input  wire logic                MEASURE_PULSE_IN,
  input  wire logic [7:0]          S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [7:0]          S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  output logic                     IRQ
);
  import ppwm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic             sync1;
    logic             sync2;
    logic             prev;
    logic [7:0]       mode;
    logic             start;
    logic             seen_first;
    logic [4:0]       sub_cnt;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] reload;
    logic [1:0]       irq_stat;
    logic [1:0]       irq_en;
    logic             irq;
    ppwm_wst_t        wst;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             awready;
    logic             wready;
    logic             arready;
  } ppwm_state_t;

  ppwm_state_t st_r;
  ppwm_state_t st_nxt;

  logic tick_eight;
  logic tick_thirtytwo;

  // ----------------------------------------------------------------
  // Prescalers
  // ----------------------------------------------------------------
  ppwm_tick #(.DIV(`PPWM_DIV_EIGHT)) u_div_eight
  (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .tick  (tick_eight)
  );

  ppwm_tick #(.DIV(`PPWM_DIV_THIRTYTWO)) u_div_thirtytwo
  (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .tick  (tick_thirtytwo)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       meas_mode;
    logic       rise;
    logic       fall;
    logic       eff_edge;
    logic       cnt_tick;
    logic       sub_tick;
    logic       do_wr;
    logic [7:0] wb;
    logic       ovf;
    logic [1:0] ev;
    logic [1:0] clr;
    ppwm_meas_t msel;
    meas_mode = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    eff_edge = 1'b0;
    cnt_tick = 1'b0;
    sub_tick = 1'b0;
    do_wr = 1'b0;
    wb = 8'h00;
    ovf = 1'b0;
    ev = 2'h0;
    clr = 2'h0;
    msel = PPWM_SEL_FALL;
    st_nxt = st_r;

    // Two-flop synchroniser, then edge compare on the clean copy
    st_nxt.sync1 = MEASURE_PULSE_IN;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    rise = st_r.sync2 & ~st_r.prev;
    fall = ~st_r.sync2 & st_r.prev;

    meas_mode = st_r.mode[`PPWM_OPMODE_LSB +: 2] == `PPWM_OPMODE_MEAS;
    msel = ppwm_meas_t'(st_r.mode[`PPWM_MEAS_LSB +: 2]);
    case (msel)
      PPWM_SEL_FALL: eff_edge = fall;
      PPWM_SEL_RISE: eff_edge = rise;
      PPWM_SEL_BOTH: eff_edge = rise | fall;
      default:       eff_edge = 1'b0; // Prohibited code, edges ignored
    endcase
    eff_edge = eff_edge & meas_mode & st_r.start;

    // Sub-clock /32 counts external sub-clock ticks
    sub_tick = 1'b0;
    if (SUBCLK_TICK)
    begin
      st_nxt.sub_cnt = st_r.sub_cnt + 5'h01;
      sub_tick = st_r.sub_cnt == 5'h1f;
    end

    case (st_r.mode[`PPWM_CLKSRC_LSB +: 2])
      2'h0:    cnt_tick = 1'b1;
      2'h1:    cnt_tick = tick_eight;
      2'h2:    cnt_tick = tick_thirtytwo;
      default: cnt_tick = sub_tick;
    endcase

    // Counter: restart on edge, count up on tick while started
    if (eff_edge)
    begin
      st_nxt.reload = st_r.count;
      st_nxt.count = '0;
      st_nxt.seen_first = 1'b1;
      ev[`PPWM_IRQ_EDGE_BIT] = st_r.seen_first;
    end
    else if (st_r.start && meas_mode && cnt_tick)
    begin
      st_nxt.count = st_r.count + 1'b1;
      ovf = &st_r.count;
    end
    if (!st_r.start)
    begin
      st_nxt.seen_first = 1'b0;
    end

    // ----- AXI write path: address and data in any order
    if (S_AXI_AWVALID && !st_r.aw_got)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st_r.w_got)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = S_AXI_WDATA;
      st_nxt.wstrb = S_AXI_WSTRB;
    end
    case (st_r.wst)
      PPWM_W_IDLE:
      begin
        if (st_r.aw_got && st_r.w_got)
        begin
          do_wr = 1'b1;
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.bvalid = 1'b1;
          st_nxt.wst = PPWM_W_RESP;
        end
      end
      PPWM_W_RESP:
      begin
        if (S_AXI_BREADY)
        begin
          st_nxt.bvalid = 1'b0;
          st_nxt.wst = PPWM_W_IDLE;
        end
      end
      default: st_nxt.wst = PPWM_W_IDLE;
    endcase
    // Hold new captures off while a response is pending
    if (st_r.wst != PPWM_W_IDLE || (st_r.aw_got && st_r.w_got))
    begin
      if (!st_r.aw_got)
      begin
        st_nxt.aw_got = st_r.aw_got;
        st_nxt.awaddr = st_r.awaddr;
      end
      if (!st_r.w_got)
      begin
        st_nxt.w_got = st_r.w_got;
        st_nxt.wdata = st_r.wdata;
        st_nxt.wstrb = st_r.wstrb;
      end
    end

    wb = st_r.wdata[7:0];
    if (do_wr)
    begin
      st_nxt.bresp = `PPWM_RESP_OKAY;
      case (st_r.awaddr)
        `PPWM_OFS_MODE:
        begin
          if (st_r.wstrb[0])
          begin
            // Overflow bit keeps hardware value; a mode write while start=1 clears it
            st_nxt.mode = {wb[7:6], st_r.mode[`PPWM_OVF_BIT] & ~st_r.start,
                           1'b0, wb[3:0]};
          end
        end
        `PPWM_OFS_TIMER: ;
        `PPWM_OFS_START:
        begin
          if (st_r.wstrb[0])
          begin
            st_nxt.start = wb[0];
          end
        end
        `PPWM_OFS_IRQ_EN:
        begin
          if (st_r.wstrb[0])
          begin
            st_nxt.irq_en = wb[1:0];
          end
        end
        `PPWM_OFS_IRQ_CLR:
        begin
          if (st_r.wstrb[0])
          begin
            clr = wb[1:0];
          end
        end
        `PPWM_OFS_IRQ_STAT: ;
        default: st_nxt.bresp = `PPWM_RESP_SLVERR;
      endcase
    end

    // Overflow sets the flag after any write; set wins over clear
    if (ovf)
    begin
      st_nxt.mode[`PPWM_OVF_BIT] = 1'b1;
    end
    ev[`PPWM_IRQ_OVF_BIT] = ovf;
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);

    // ----- AXI read path, one read at a time
    if (st_r.rvalid)
    begin
      if (S_AXI_RREADY)
      begin
        st_nxt.rvalid = 1'b0;
      end
    end
    else if (S_AXI_ARVALID)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `PPWM_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      case (S_AXI_ARADDR)
        `PPWM_OFS_MODE:     st_nxt.rdata[7:0] = st_r.mode;
        `PPWM_OFS_TIMER:    st_nxt.rdata[CNT_W-1:0] = st_r.reload;
        `PPWM_OFS_START:    st_nxt.rdata[0] = st_r.start;
        `PPWM_OFS_IRQ_STAT: st_nxt.rdata[1:0] = st_r.irq_stat;
        `PPWM_OFS_IRQ_EN:   st_nxt.rdata[1:0] = st_r.irq_en;
        `PPWM_OFS_IRQ_CLR:  st_nxt.rdata = 32'h0000_0000;
        default:            st_nxt.rresp = `PPWM_RESP_SLVERR;
      endcase
    end

    // Ready flags registered from the next state, so they match the gates they replace
    st_nxt.awready = ~st_nxt.aw_got & (st_nxt.wst == PPWM_W_IDLE);
    st_nxt.wready = ~st_nxt.w_got & (st_nxt.wst == PPWM_W_IDLE);
    st_nxt.arready = ~st_nxt.rvalid;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_r <= '0;
      st_r.mode <= `PPWM_MODE_RST;
      st_r.wst <= PPWM_W_IDLE;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops; ready only while slot free
  assign S_AXI_AWREADY = st_r.awready;
  assign S_AXI_WREADY  = st_r.wready;
  assign S_AXI_BVALID  = st_r.bvalid;
  assign S_AXI_BRESP   = st_r.bresp;
  assign S_AXI_ARREADY = st_r.arready;
  assign S_AXI_RVALID  = st_r.rvalid;
  assign S_AXI_RDATA   = st_r.rdata;
  assign S_AXI_RRESP   = st_r.rresp;
  assign IRQ           = st_r.irq;
endmodule

// *** logic/ppwm_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the measurement channel
`ifndef PPWM_CFG_SVH
`define PPWM_CFG_SVH

// Register byte offsets
`define PPWM_OFS_MODE      8'h00
`define PPWM_OFS_TIMER     8'h04
`define PPWM_OFS_START     8'h08
`define PPWM_OFS_IRQ_STAT  8'h0c
`define PPWM_OFS_IRQ_EN    8'h10
`define PPWM_OFS_IRQ_CLR   8'h14

// Mode register fields
`define PPWM_OPMODE_LSB    0
`define PPWM_MEAS_LSB      2
`define PPWM_OVF_BIT       5
`define PPWM_CLKSRC_LSB    6
`define PPWM_OPMODE_MEAS   2'h2
`define PPWM_MODE_RST      8'h00

// Interrupt status bits
`define PPWM_IRQ_EDGE_BIT  0
`define PPWM_IRQ_OVF_BIT   1

// Prescaler ratios
`define PPWM_DIV_EIGHT     8
`define PPWM_DIV_THIRTYTWO 32

// AXI responses
`define PPWM_RESP_OKAY     2'h0
`define PPWM_RESP_SLVERR   2'h2

`endif

// *** logic/ppwm_pkg.sv ***
// Types shared by the measurement channel
package ppwm_pkg;
  typedef enum logic [1:0]
  {
    PPWM_SEL_FALL = 2'h0,
    PPWM_SEL_RISE = 2'h1,
    PPWM_SEL_BOTH = 2'h2,
    PPWM_SEL_BAD  = 2'h3
  } ppwm_meas_t;

  typedef enum logic [2:0]
  {
    PPWM_W_IDLE = 3'h1,
    PPWM_W_RESP = 3'h2,
    PPWM_W_HOLD = 3'h4
  } ppwm_wst_t;
endpackage

// *** logic/ppwm_tick.sv ***
// Free running prescaler that issues a one-cycle tick every DIV clocks
`timescale 1ns/1ns
module ppwm_tick
#(
  parameter int DIV = 8
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  typedef struct packed
  {
    logic [7:0] cnt;
    logic       tick;
  } ppwm_tick_t;

  ppwm_tick_t st_r;
  ppwm_tick_t st_nxt;

  // Count to DIV-1 then wrap with a tick
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == 8'(DIV - 1))
    begin
      st_nxt.cnt = 8'h00;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule

// *** verif/ppwm_chk.sv ***
// Checker of register bus handshakes and read answers of the channel
`timescale 1ns/1ns
`include "ppwm_cfg.svh"
module ppwm_chk
(
  input wire logic        REF_CLK,
  input wire logic        RSTN,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  // Answers stand until the master takes them
  a_bvalid_holds:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
  a_rdata_holds:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read answer changed");
  // Answer latency fixed by the hand-over timing
  a_read_answer:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("late rvalid");
  a_write_answer:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2
      S_AXI_BVALID) else $error("late bvalid");
  // No new request taken while an answer is pending
  a_ar_blocked:
    assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("arready with rvalid");
  a_aw_blocked:
    assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("wready busy");
  // Unmapped place answers an error with zero data
  a_unmapped_err:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h18 |=>
      S_AXI_RRESP == `PPWM_RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("unmapped read");
  a_timer_width:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `PPWM_OFS_TIMER |=>
      S_AXI_RDATA[31:16] == 16'h0) else $error("timer upper bits set");
endmodule

bind ppwm_top ppwm_chk i_ppwm_chk
(
  .REF_CLK, .RSTN, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
  .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY
);

// *** verif/ppwm_pulse_src.sv ***
// Model of the external pulse source on the measurement input
`timescale 1ns/1ns
module ppwm_pulse_src
(
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] hi_len,
  input  wire logic [15:0] lo_len,
  output logic             pulse
);
  logic [15:0] cnt;

  // Idles high; a stopped source keeps its level, so stopping makes no edge
  initial
  begin
    pulse = 1'b1;
    cnt = 16'h0;
  end

  // High for hi_len cycles, low for lo_len cycles
  always @(posedge clk)
  begin
    if (run)
    begin
      cnt <= cnt + 16'h1;
      if (cnt + 16'h1 >= (pulse ? hi_len : lo_len))
      begin
        pulse <= ~pulse;
        cnt <= 16'h0;
      end
    end
  end
endmodule

// *** verif/ppwm_top_test.sv ***
// Self-checking bench of the measurement channel
`timescale 1ns/1ns
`include "ppwm_cfg.svh"
module ppwm_top_test;
  logic        clk, rstn, sub_tick, run, pulse;
  logic [15:0] hi_len, lo_len;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  int          fails = 0;
  int          n_compared = 0;
  // Mode, high and low lengths, accepted results per row
  logic [7:0]  t_mode [6] = '{8'h02, 8'h42, 8'h82, 8'hc2, 8'h06, 8'h0a};
  int          t_hi [6] = '{64, 64, 64, 64, 10, 10};
  int          t_lo [6] = '{64, 64, 64, 64, 30, 30};
  int          t_e0 [6] = '{127, 15, 3, 1, 39, 9};
  int          t_e1 [6] = '{127, 16, 4, 2, 39, 29};

  ppwm_top i_ppwm_top
  (
    .REF_CLK(clk), .RSTN(rstn), .SUBCLK_TICK(sub_tick), .MEASURE_PULSE_IN(pulse),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IRQ(irq)
  );

  ppwm_pulse_src i_ppwm_pulse_src
  (
    .clk(clk), .run(run), .hi_len(hi_len), .lo_len(lo_len), .pulse(pulse)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Sub-clock tick every second cycle, so source 11 counts once per 64 clocks
  always @(posedge clk) sub_tick <= ~sub_tick;

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e0,
                     input logic [31:0] e1);
    n_compared++;
    if (s !== e0 && s !== e1)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e0, s);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge clk);
      ad = ad | awready;
      wd = wd | wready;
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
    end
    // Ready held back one cycle so the answer is seen to stand
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e0, input logic [31:0] e1,
                     input string n);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    chk(n, v, e0, e1);
  endtask

  task automatic wrap_up();
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cut a hang short well past the expected run of about 70k cycles
  initial
  begin
    #1000000;
    fails++;
    wrap_up();
  end

  initial
  begin
    {rstn, sub_tick, run, awvalid, wvalid, bready, arvalid, rready} = 8'h0;
    {awaddr, araddr, wdata} = 48'h0;
    hi_len = 16'd10;
    lo_len = 16'd30;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, unmapped place, read-only overflow flag
    rdc(`PPWM_OFS_MODE, 32'h0, 32'h0, "mode reset");
    rdc(`PPWM_OFS_IRQ_STAT, 32'h0, 32'h0, "status reset");
    rdc(8'h18, 32'h0, 32'h0, "unmapped data");
    chk("unmapped resp", {30'h0, r}, {30'h0, `PPWM_RESP_SLVERR}, {30'h0, `PPWM_RESP_SLVERR});
    wr(8'h18, 32'h0);
    chk("unmapped wresp", {30'h0, r}, {30'h0, `PPWM_RESP_SLVERR}, {30'h0, `PPWM_RESP_SLVERR});
    wr(`PPWM_OFS_MODE, 32'h22);
    rdc(`PPWM_OFS_MODE, 32'h02, 32'h02, "mode flag");
    // First edge silent, rising edge ignored, second falling edge flagged
    wr(`PPWM_OFS_IRQ_EN, 32'h3);
    wr(`PPWM_OFS_START, 32'h1);
    run <= 1'b1;
    repeat (15) @(posedge clk);
    rdc(`PPWM_OFS_IRQ_STAT, 32'h0, 32'h0, "first edge");
    repeat (25) @(posedge clk);
    rdc(`PPWM_OFS_IRQ_STAT, 32'h0, 32'h0, "rise ignored");
    repeat (15) @(posedge clk);
    rdc(`PPWM_OFS_IRQ_STAT, 32'h1, 32'h1, "edge status");
    chk("irq edge", {31'h0, irq}, 32'h1, 32'h1);
    run <= 1'b0;
    // Every source and every legal edge select; code 11 is never programmed
    for (int i = 0; i < 6; i++)
    begin
      wr(`PPWM_OFS_START, 32'h0);
      wr(`PPWM_OFS_MODE, {24'h0, t_mode[i]});
      wr(`PPWM_OFS_START, 32'h1);
      hi_len <= 16'(t_hi[i]);
      lo_len <= 16'(t_lo[i]);
      run <= 1'b1;
      repeat (3 * (t_hi[i] + t_lo[i]) + 10) @(posedge clk);
      rdc(`PPWM_OFS_TIMER, t_e0[i], t_e1[i], "result");
      wr(`PPWM_OFS_TIMER, 32'hffff);
      rdc(`PPWM_OFS_TIMER, t_e0[i], t_e1[i], "after write");
      run <= 1'b0;
    end
    // Overflow with the pulse stopped, then mask, flag clear and status clear
    // Let a last edge still in the synchroniser land before the clear
    repeat (8) @(posedge clk);
    wr(`PPWM_OFS_IRQ_CLR, 32'h3);
    wr(`PPWM_OFS_MODE, 32'h02);
    repeat (65600) @(posedge clk);
    rdc(`PPWM_OFS_MODE, 32'h22, 32'h22, "overflow flag");
    rdc(`PPWM_OFS_IRQ_STAT, 32'h2, 32'h2, "overflow status");
    chk("irq overflow", {31'h0, irq}, 32'h1, 32'h1);
    wr(`PPWM_OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0, 32'h0);
    wr(`PPWM_OFS_MODE, 32'h02);
    rdc(`PPWM_OFS_MODE, 32'h02, 32'h02, "flag cleared");
    wr(`PPWM_OFS_IRQ_CLR, 32'h3);
    wr(`PPWM_OFS_IRQ_EN, 32'h3);
    rdc(`PPWM_OFS_IRQ_STAT, 32'h0, 32'h0, "status cleared");
    chk("irq cleared", {31'h0, irq}, 32'h0, 32'h0);
    wrap_up();
  end
endmodule
